// [hw/debug_port_access.sv]
// Access layer of a one-wire debug port: keys, info block, resets, erase.
// Assumes link framing is done outside; its events arrive synchronous to hclk.
// How it works
// - Each rising line edge inside a sync character gives an unmaskable event.
// - Multibyte readout separates bytes by two idle bits by default.
// - Gap option adds a fixed two stop bits, only between bytes.
// - First byte after turnaround waits the guard time only, no gap.
// - Info-block request returns the block whatever the lock or key state.
// - Block order: identifier 0-6, reserved, versions, reserved, oscillator byte.
// - Three fixed 64-bit key values, least significant byte shifted first.
// - Erase key needs nothing; program key needs unlock; user-row key needs lock.
// - Keys clear by port reset; erase key also by disable, program key by completion, user-row key by status write.
// - Erase key arriving later leaves an active program key alone.
// - Key status shows one bit per accepted key.
// - Reset signature asserts system reset; writing zero releases it.
// - Locked device refuses system bus; full access after erase.
// - Erase forces brownout detector active with the fused threshold.
// - User-row mode takes first 32 RAM bytes only, no readback, copy.
// - Key transfers are 64 bits and get no answer.
// - Control A bit 7 enables the interbyte gap.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module debug_port_access #(
  parameter int BIT_CYCLES = 8,
  parameter int ERASE_CYCLES = 64,
  parameter logic [7:0] RESET_SIGNATURE = 8'hA5,
  // Arbitrary information-block contents
  parameter logic [55:0] FAMILY_IDENTIFIER = 56'h30303030303030,
  parameter logic [23:0] NONVOLATILE_INTERFACE_VERSION = 24'h303030,
  parameter logic [23:0] ON_CHIP_DEBUG_VERSION = 24'h303030,
  parameter logic [7:0] DEBUG_OSCILLATOR_FREQUENCY = 8'h30
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Link side
  input wire logic sync_window,
  input wire logic sync_line,
  output logic sync_event,
  input wire logic key_start,
  input wire logic key_info,
  input wire logic [4:0] key_size_bytes,
  input wire logic key_byte_valid,
  input wire logic [7:0] key_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_busy,
  // System side
  input wire logic lock_fuse,
  input wire logic [2:0] brownout_fuse_level,
  input wire logic in_sleep,
  input wire logic port_disable,
  input wire logic port_reset,
  output logic sys_reset,
  output logic [1:0] brownout_active,
  output logic [2:0] brownout_level,
  output logic sys_bus_grant,
  output logic ram_read_allowed,
  output logic clk_request,
  // User row
  input wire logic ram_wr_valid,
  input wire logic [15:0] ram_wr_addr,
  input wire logic [7:0] ram_wr_data,
  output logic urow_wr_valid,
  output logic [4:0] urow_wr_addr,
  output logic [7:0] urow_wr_data
);
  typedef struct packed {
    logic rdy;
    logic dsel;
    logic dwrite;
    logic [3:0] didx;
    logic [7:0] rdata;
    logic gap_en;
    logic erase_key;
    logic prog_key;
    logic urow_key;
    logic [7:0] rst_val;
    logic sys_reset;
    logic clk_req;
    logic lock_loaded;
    logic lock;
    logic erase_busy;
    logic [15:0] erase_cnt;
    logic [1:0] brownout_act;
    logic [2:0] brownout_lvl;
    logic prog_ready;
    logic urow_ready;
    logic copying;
    logic [4:0] copy_idx;
    logic uw_valid;
    logic [4:0] uw_addr;
    logic [7:0] uw_data;
    logic [31:0][7:0] ram;
    logic sync_prev;
    logic sync_ev;
    logic grant;
  } access_state_type;

  localparam access_state_type RESET_ST = '{rdy: 1'b1, lock: 1'b1, clk_req: 1'b1, default: '0};
  localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);

  access_state_type st_ff, nxt_st;
  logic hit_erase, hit_prog, hit_urow;
  logic released, asserted, wr_now;
  logic [7:0] wbyte;

  localparam logic [127:0] INFO_BLOCK = {DEBUG_OSCILLATOR_FREQUENCY, 8'h00,
    ON_CHIP_DEBUG_VERSION, NONVOLATILE_INTERFACE_VERSION, 8'h00, FAMILY_IDENTIFIER};

  function automatic logic [7:0] read_reg(input access_state_type s, input logic [3:0] idx,
                                           input logic sleep);
    read_reg = 8'h00;
    case (idx)
      debug_port_pkg::IDX_CTRL_A: read_reg[debug_port_pkg::CTRLA_GAP_BIT] = s.gap_en;
      debug_port_pkg::IDX_KEY_STATUS: begin
        read_reg[debug_port_pkg::KS_ERASE_BIT] = s.erase_key;
        read_reg[debug_port_pkg::KS_PROG_BIT] = s.prog_key;
        read_reg[debug_port_pkg::KS_UROW_BIT] = s.urow_key;
      end
      debug_port_pkg::IDX_RESET_REQ: read_reg = s.rst_val;
      debug_port_pkg::IDX_SYS_CTRL: read_reg[debug_port_pkg::SC_CLKREQ_BIT] = s.clk_req;
      debug_port_pkg::IDX_SYS_STATUS: begin
        read_reg[debug_port_pkg::SS_LOCK_BIT] = s.lock;
        read_reg[debug_port_pkg::SS_UROW_READY_BIT] = s.urow_ready;
        read_reg[debug_port_pkg::SS_PROG_READY_BIT] = s.prog_ready;
        read_reg[debug_port_pkg::SS_SLEEP_BIT] = sleep;
        read_reg[debug_port_pkg::SS_RSTSYS_BIT] = s.sys_reset;
      end
      default: read_reg = 8'h00;
    endcase
  endfunction

  // key bytes feed only the matcher
  key_matcher u_keys (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .key_begin(key_start),
    .byte_valid(key_byte_valid && !key_info),
    .byte_data(key_byte),
    .hit_erase(hit_erase),
    .hit_prog(hit_prog),
    .hit_urow(hit_urow)
  );

  // readout in any lock or key state
  byte_pacer #(.BIT_CYCLES(BIT_CYCLES)) u_pacer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(key_start && key_info),
    .nbytes(key_size_bytes),
    .gap_en(st_ff.gap_en),
    .data(INFO_BLOCK),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .busy(tx_busy)
  );

  assign wr_now = st_ff.dsel && st_ff.dwrite;
  assign wbyte = hwdata[7:0];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.uw_valid = 1'b0;
    nxt_st.rdy = 1'b1;
    // Address phase; reads are answered in the following data phase
    nxt_st.dsel = hsel && hready && (htrans == debug_port_pkg::HTRANS_NONSEQ);
    nxt_st.dwrite = hwrite;
    nxt_st.didx = haddr[5:2];
    nxt_st.rdata = read_reg(st_ff, haddr[5:2], in_sleep);
    if (!st_ff.lock_loaded) begin
      nxt_st.lock_loaded = 1'b1;
      nxt_st.lock = lock_fuse;
    end
    nxt_st.sync_prev = sync_line;
    nxt_st.sync_ev = sync_window && sync_line && !st_ff.sync_prev;
    if (wr_now) begin
      case (st_ff.didx)
        debug_port_pkg::IDX_CTRL_A: nxt_st.gap_en = wbyte[debug_port_pkg::CTRLA_GAP_BIT];
        debug_port_pkg::IDX_KEY_STATUS: begin
          if (wbyte[debug_port_pkg::KS_UROW_BIT]) begin
            nxt_st.urow_key = 1'b0;
            nxt_st.urow_ready = 1'b0;
          end
        end
        debug_port_pkg::IDX_RESET_REQ: begin
          nxt_st.rst_val = wbyte;
          if (wbyte == RESET_SIGNATURE) begin
            nxt_st.sys_reset = 1'b1;
          end else if (wbyte == debug_port_pkg::RESET_RELEASE) begin
            nxt_st.sys_reset = 1'b0;
          end
        end
        debug_port_pkg::IDX_SYS_CTRL: begin
          nxt_st.clk_req = wbyte[debug_port_pkg::SC_CLKREQ_BIT];
          if (wbyte[debug_port_pkg::SC_COMMIT_BIT] && st_ff.urow_ready && !st_ff.copying) begin
            nxt_st.copying = 1'b1;
            nxt_st.copy_idx = 5'h00;
          end
        end
        default: nxt_st.rst_val = st_ff.rst_val;
      endcase
    end
    released = st_ff.sys_reset && !nxt_st.sys_reset;
    asserted = !st_ff.sys_reset && nxt_st.sys_reset;
    // programming completes on the next reset
    if (asserted && st_ff.prog_ready) begin
      nxt_st.prog_key = 1'b0;
      nxt_st.prog_ready = 1'b0;
    end
    if (released && st_ff.erase_key && !st_ff.erase_busy) begin
      nxt_st.erase_busy = 1'b1;
      nxt_st.erase_cnt = 16'h0000;
      nxt_st.brownout_act = debug_port_pkg::BROWNOUT_ACTIVE_ON;
      nxt_st.brownout_lvl = brownout_fuse_level;
    end
    if (st_ff.erase_busy) begin
      nxt_st.erase_cnt = st_ff.erase_cnt + 16'h0001;
      if (st_ff.erase_cnt == ERASE_LAST) begin
        nxt_st.erase_busy = 1'b0;
        nxt_st.lock = 1'b0;
        nxt_st.brownout_act = 2'h0;
      end
    end
    if (released && st_ff.prog_key && !st_ff.lock) begin
      nxt_st.prog_ready = 1'b1;
    end
    if (released && st_ff.urow_key && st_ff.lock) begin
      nxt_st.urow_ready = 1'b1;
    end
    if (ram_wr_valid && st_ff.urow_ready && !st_ff.copying &&
        ram_wr_addr < debug_port_pkg::USER_ROW_BYTES) begin
      nxt_st.ram[ram_wr_addr[4:0]] = ram_wr_data;
    end
    if (st_ff.copying) begin
      nxt_st.uw_valid = 1'b1;
      nxt_st.uw_addr = st_ff.copy_idx;
      nxt_st.uw_data = st_ff.ram[st_ff.copy_idx];
      nxt_st.copy_idx = st_ff.copy_idx + 5'h01;
      if (st_ff.copy_idx == 5'h1F) begin
        nxt_st.copying = 1'b0;
        nxt_st.urow_ready = 1'b0;
      end
    end
    // disable clears the erase key; port reset clears all keys
    if (port_disable || port_reset) begin
      nxt_st.erase_key = 1'b0;
    end
    if (port_reset) begin
      nxt_st.prog_key = 1'b0;
      nxt_st.urow_key = 1'b0;
      nxt_st.prog_ready = 1'b0;
      nxt_st.urow_ready = 1'b0;
    end
    // erase match leaves program key; a new match wins over a clear
    if (hit_erase) begin
      nxt_st.erase_key = 1'b1;
    end
    if (hit_prog) begin
      nxt_st.prog_key = 1'b1;
    end
    if (hit_urow) begin
      nxt_st.urow_key = 1'b1;
    end
    nxt_st.grant = !nxt_st.lock;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= RESET_ST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.rdy;
  assign hrdata = {24'h000000, st_ff.rdata};
  assign hresp = 1'b0;
  assign sync_event = st_ff.sync_ev;
  assign sys_reset = st_ff.sys_reset;
  assign brownout_active = st_ff.brownout_act;
  assign brownout_level = st_ff.brownout_lvl;
  assign sys_bus_grant = st_ff.grant;
  assign ram_read_allowed = !st_ff.urow_ready;
  assign clk_request = st_ff.clk_req;
  assign urow_wr_valid = st_ff.uw_valid;
  assign urow_wr_addr = st_ff.uw_addr;
  assign urow_wr_data = st_ff.uw_data;

  property p_sync_event;
    @(posedge hclk) disable iff (!hresetn)
      (ce && sync_window && sync_line && !$past(sync_line) && $past(ce)) |=> sync_event;
  endproperty
  a_sync_event: assert property (p_sync_event) else $error("sync edge event missing");

  // Level is the fuse value seen at erase start, then held
  property p_erase_brownout;
    @(posedge hclk) disable iff (!hresetn)
      st_ff.erase_busy |-> brownout_active == debug_port_pkg::BROWNOUT_ACTIVE_ON &&
        ($rose(st_ff.erase_busy) ? brownout_level == $past(brownout_fuse_level)
        : $stable(brownout_level));
  endproperty
  a_erase_brownout: assert property (p_erase_brownout) else $error("brownout not forced");

  property p_lock_bus;
    @(posedge hclk) disable iff (!hresetn) st_ff.lock |-> !sys_bus_grant;
  endproperty
  a_lock_bus: assert property (p_lock_bus) else $error("bus granted while locked");

  property p_prog_unlocked;
    @(posedge hclk) disable iff (!hresetn) st_ff.prog_ready |-> !st_ff.lock && st_ff.prog_key;
  endproperty
  a_prog_unlocked: assert property (p_prog_unlocked) else $error("program ready while locked");

  property p_urow_locked;
    @(posedge hclk) disable iff (!hresetn) st_ff.urow_ready |-> st_ff.lock;
  endproperty
  a_urow_locked: assert property (p_urow_locked) else $error("user row ready while unlocked");

  property p_reset_req;
    @(posedge hclk) disable iff (!hresetn)
      (ce && wr_now && st_ff.didx == debug_port_pkg::IDX_RESET_REQ && wbyte == RESET_SIGNATURE)
      |=> sys_reset;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset signature ignored");

  property p_urow_range;
    @(posedge hclk) disable iff (!hresetn)
      (ram_wr_valid && ram_wr_addr >= debug_port_pkg::USER_ROW_BYTES) |=> $stable(st_ff.ram);
  endproperty
  a_urow_range: assert property (p_urow_range) else $error("out of range RAM write taken");

  property p_prog_kept;
    @(posedge hclk) disable iff (!hresetn)
      (ce && st_ff.prog_key && hit_erase && !port_reset && !st_ff.prog_ready) |=> st_ff.prog_key;
  endproperty
  a_prog_kept: assert property (p_prog_kept) else $error("erase key cleared program key");

  c_erase_done: cover property (@(posedge hclk) disable iff (!hresetn) $fell(st_ff.erase_busy));
  c_prog_ready: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_ff.prog_ready));
  c_urow_copy: cover property (@(posedge hclk) disable iff (!hresetn) $fell(st_ff.copying));
endmodule

// [hw/debug_port_pkg.sv]
// Shared constants of the debug-port key and access logic.
// Assumes a 100 MHz bus clock; link timing is counted in bus clocks per bit.
package debug_port_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL_A = 4'h2;
  localparam logic [3:0] IDX_KEY_STATUS = 4'h7;
  localparam logic [3:0] IDX_RESET_REQ = 4'h8;
  localparam logic [3:0] IDX_SYS_CTRL = 4'hA;
  localparam logic [3:0] IDX_SYS_STATUS = 4'hB;
  // Field positions
  localparam int CTRLA_GAP_BIT = 7;
  localparam int KS_ERASE_BIT = 3;
  localparam int KS_PROG_BIT = 4;
  localparam int KS_UROW_BIT = 5;
  localparam int SC_CLKREQ_BIT = 0;
  localparam int SC_COMMIT_BIT = 1;
  localparam int SS_LOCK_BIT = 0;
  localparam int SS_UROW_READY_BIT = 2;
  localparam int SS_PROG_READY_BIT = 3;
  localparam int SS_SLEEP_BIT = 4;
  localparam int SS_RSTSYS_BIT = 5;
  // Values
  localparam logic [7:0] RESET_RELEASE = 8'h00;
  localparam logic [1:0] BROWNOUT_ACTIVE_ON = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [63:0] KEY_ERASE = 64'h4E564D4572617365;
  localparam logic [63:0] KEY_PROG = 64'h4E564D50726F6720;
  localparam logic [63:0] KEY_UROW = 64'h4E564D5573267465;
  // Counts
  localparam logic [3:0] KEY_BYTES = 4'h8;
  localparam logic [15:0] USER_ROW_BYTES = 16'h0020;
  localparam int FRAME_BITS = 12;
  localparam int IDLE_BITS = 2;
  localparam int GAP_EXTRA_BITS = 2;
  localparam int GUARD_BITS = 128;
endpackage

// [hw/key_matcher.sv]
// Shifts in 64-bit key values byte by byte, least significant byte first.
// Assumes key_begin marks a new key instruction before its first byte.
`timescale 1ns/1ps
module key_matcher (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Key bytes
  input wire logic key_begin,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Match pulses
  output logic hit_erase,
  output logic hit_prog,
  output logic hit_urow
);
  typedef struct packed {
    logic [63:0] shreg;
    logic [3:0] cnt;
    logic he;
    logic hp;
    logic hu;
  } match_state_type;

  match_state_type st_ff, nxt_st;
  logic [63:0] shifted;
  localparam logic [3:0] KEY_BYTES_M1 = debug_port_pkg::KEY_BYTES - 4'h1;

  function automatic logic key_is(input logic [63:0] v, input logic [63:0] k);
    key_is = (v == k);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.he = 1'b0;
    nxt_st.hp = 1'b0;
    nxt_st.hu = 1'b0;
    shifted = {byte_data, st_ff.shreg[63:8]};
    if (key_begin) begin
      nxt_st.cnt = 4'h0;
    end else if (byte_valid) begin
      nxt_st.shreg = shifted;
      nxt_st.cnt = st_ff.cnt + 4'h1;
      if (st_ff.cnt == KEY_BYTES_M1) begin
        nxt_st.cnt = 4'h0;
        nxt_st.he = key_is(shifted, debug_port_pkg::KEY_ERASE);
        nxt_st.hp = key_is(shifted, debug_port_pkg::KEY_PROG);
        nxt_st.hu = key_is(shifted, debug_port_pkg::KEY_UROW);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign hit_erase = st_ff.he;
  assign hit_prog = st_ff.hp;
  assign hit_urow = st_ff.hu;

  property p_key_onehot;
    @(posedge hclk) disable iff (!hresetn) $onehot0({hit_erase, hit_prog, hit_urow});
  endproperty
  a_key_onehot: assert property (p_key_onehot) else $error("two keys matched");

  property p_key_hit_cause;
    @(posedge hclk) disable iff (!hresetn)
      (hit_erase || hit_prog || hit_urow) |-> $past(byte_valid) && $past(st_ff.cnt) == 4'h7;
  endproperty
  a_key_hit_cause: assert property (p_key_hit_cause) else $error("match without 8th byte");
endmodule

// [hw/byte_pacer.sv]
// Paces outgoing information-block bytes: guard time first, then gaps.
// Assumes the link serializer takes one byte per tx_valid pulse.
`timescale 1ns/1ps
module byte_pacer #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [4:0] nbytes,
  input wire logic gap_en,
  input wire logic [127:0] data,
  // Byte stream
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic busy
);
  typedef struct packed {
    logic busy;
    logic gap;
    logic [4:0] idx;
    logic [4:0] left;
    logic [15:0] cnt;
    logic tv;
    logic [7:0] tb;
  } pacer_state_type;

  localparam logic [15:0] GUARD_CYC = 16'(debug_port_pkg::GUARD_BITS * BIT_CYCLES - 1);
  localparam logic [15:0] BASE_CYC =
    16'((debug_port_pkg::FRAME_BITS + debug_port_pkg::IDLE_BITS) * BIT_CYCLES);
  localparam logic [15:0] EXTRA_CYC = 16'(debug_port_pkg::GAP_EXTRA_BITS * BIT_CYCLES);

  pacer_state_type st_ff, nxt_st;
  logic [15:0] spacing;

  assign spacing = st_ff.gap ? BASE_CYC + EXTRA_CYC : BASE_CYC;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tv = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.gap = gap_en;
      nxt_st.idx = 5'h00;
      nxt_st.left = nbytes;
      nxt_st.cnt = GUARD_CYC;
    end else if (st_ff.busy) begin
      if (st_ff.cnt != 16'h0000) begin
        nxt_st.cnt = st_ff.cnt - 16'h0001;
      end else if (st_ff.left == 5'h00) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.tv = 1'b1;
        nxt_st.tb = data[{st_ff.idx[3:0], 3'b000} +: 8];
        nxt_st.idx = st_ff.idx + 5'h01;
        nxt_st.left = st_ff.left - 5'h01;
        nxt_st.cnt = spacing - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign tx_valid = st_ff.tv;
  assign tx_byte = st_ff.tb;
  assign busy = st_ff.busy;

  // Cycles since the previous byte, for checking only
  logic [15:0] since_ff;
  logic seen_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_ff <= 16'h0000;
      seen_ff <= 1'b0;
    end else if (ce) begin
      since_ff <= st_ff.tv ? 16'h0001 : since_ff + 16'h0001;
      seen_ff <= start ? 1'b0 : (seen_ff | st_ff.tv);
    end
  end

  property p_byte_spacing;
    @(posedge hclk) disable iff (!hresetn)
      (tx_valid && seen_ff && !$past(start)) |-> since_ff == spacing;
  endproperty
  a_byte_spacing: assert property (p_byte_spacing) else $error("bad interbyte spacing");

  property p_guard_first;
    @(posedge hclk) disable iff (!hresetn)
      (ce && start && nbytes != 5'h00) |=> !tx_valid [*8];
  endproperty
  a_guard_first: assert property (p_guard_first) else $error("first byte too early");
endmodule

// [test/link_host.sv]
// Programmer-side model of the key link: key and info-block requests.
// Assumes one go pulse per request and at least ten clocks between requests.
`timescale 1ns/1ps
module link_host (
  // Clock and command
  input wire logic hclk,
  input wire logic go,
  input wire logic info,
  input wire logic [4:0] size,
  input wire logic [63:0] key,
  // Key link
  output logic key_start,
  output logic key_info,
  output logic [4:0] key_size_bytes,
  output logic key_byte_valid,
  output logic [7:0] key_byte
);
  int n = 8;
  initial begin
    key_start = 1'b0;
    key_info = 1'b0;
    key_size_bytes = 5'h00;
    key_byte_valid = 1'b0;
    key_byte = 8'h00;
  end
  always @(posedge hclk) begin
    key_start <= go;
    key_byte_valid <= 1'b0;
    if (go) begin
      key_info <= info;
      key_size_bytes <= size;
      n <= info ? 8 : 0;
      key_byte <= ~key_byte;
    end else if (n < 8) begin
      key_byte_valid <= 1'b1;
      key_byte <= key[8*n+:8];
      n <= n + 1;
    end else begin
      // Idle line inverts the stale byte every clock instead of holding it
      key_byte <= ~key_byte;
    end
  end
endmodule

// [test/debug_port_access_tb.sv]
// Self-checking bench of the debug-port access layer.
// Assumes link_host drives the key link and one AHB-Lite master does singles.
`timescale 1ns/1ps
module debug_port_access_tb;
  localparam logic [127:0] INFO = {8'h39, 8'h00, 24'h353637, 24'h313233, 8'h00,
    56'h41424344454647};
  localparam logic [31:0] RSIG = 32'h000000A5;
  localparam int SP = debug_port_pkg::FRAME_BITS + debug_port_pkg::IDLE_BITS;
  localparam logic [7:0] ctrl_addr = {2'b00, debug_port_pkg::IDX_CTRL_A, 2'b00};
  localparam logic [7:0] keys_addr = {2'b00, debug_port_pkg::IDX_KEY_STATUS, 2'b00};
  localparam logic [7:0] rreq_addr = {2'b00, debug_port_pkg::IDX_RESET_REQ, 2'b00};
  localparam logic [7:0] sctl_addr = {2'b00, debug_port_pkg::IDX_SYS_CTRL, 2'b00};
  localparam logic [7:0] stat_addr = {2'b00, debug_port_pkg::IDX_SYS_STATUS, 2'b00};
  logic hclk, hresetn, ce, hsel, hwrite, chk, go, info, sync_window, sync_line;
  logic ram_wr_valid, port_disable, port_reset, in_sleep;
  logic rd_pend = 1'b0;
  logic [1:0] htrans;
  logic [4:0] size;
  logic [7:0] ram_wr_data, d;
  logic [15:0] ram_wr_addr;
  logic [31:0] haddr, hwdata, seed;
  logic [63:0] key;
  wire hreadyout, sync_event, key_start, key_info, key_byte_valid, tx_valid, tx_busy;
  wire sys_reset, sys_bus_grant, ram_read_allowed, urow_wr_valid, hresp, clk_request;
  wire [1:0] brownout_active;
  wire [2:0] brownout_level;
  wire [4:0] key_size_bytes, urow_wr_addr;
  wire [7:0] key_byte, tx_byte, urow_wr_data;
  wire [31:0] hrdata;
  int mismatches = 0, total_checks = 0, ev_cnt = 0, exp_ev;
  time t_ref;
  logic [31:0] rq[$];
  logic [23:0] tq[$];
  logic [12:0] uq[$];
  debug_port_access #(.BIT_CYCLES(1), .ERASE_CYCLES(8), .RESET_SIGNATURE(RSIG[7:0]),
    .FAMILY_IDENTIFIER(INFO[55:0]), .NONVOLATILE_INTERFACE_VERSION(INFO[87:64]),
    .ON_CHIP_DEBUG_VERSION(INFO[111:88]), .DEBUG_OSCILLATOR_FREQUENCY(INFO[127:120])
  ) debug_port_access_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .sync_window, .sync_line, .sync_event, .key_start, .key_info, .key_size_bytes,
    .key_byte_valid, .key_byte, .tx_valid, .tx_byte, .tx_busy, .lock_fuse(1'b1),
    .brownout_fuse_level(3'h5), .in_sleep, .port_disable, .port_reset, .sys_reset,
    .brownout_active, .brownout_level, .sys_bus_grant, .ram_read_allowed, .clk_request,
    .ram_wr_valid, .ram_wr_addr, .ram_wr_data, .urow_wr_valid, .urow_wr_addr, .urow_wr_data);
  link_host link_host_inst (.hclk, .go, .info, .size, .key, .key_start, .key_info,
    .key_size_bytes, .key_byte_valid, .key_byte);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic c);
    hsel <= 1'b1;
    htrans <= debug_port_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    chk <= c;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 1'b0);
  endtask
  task automatic send(input logic s, input logic [4:0] n, input logic [63:0] k);
    go <= 1'b1;
    info <= s;
    size <= n;
    key <= k;
    @(posedge hclk);
    go <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask
  task automatic stream(input logic g, input int n);
    wr(ctrl_addr, {24'h0, g, 7'h00});
    for (int i = 0; i < n; i++)
      tq.push_back({16'(i == 0 ? debug_port_pkg::GUARD_BITS + 1 : SP + 2 * g), INFO[8*i+:8]});
    send(1'b1, 5'(n), 64'h0);
    repeat (400) @(posedge hclk);
    check(32'(tq.size()), 32'h0);
    check({30'h0, tx_busy, hresp}, 32'h0);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rd_pend) check(hrdata, rq.pop_front());
    rd_pend <= hsel && htrans == debug_port_pkg::HTRANS_NONSEQ && !hwrite && chk;
    if (key_start && key_info) t_ref <= $time;
    if (tx_valid) begin
      check({8'h0, 16'(($time - t_ref) / 10), tx_byte}, {8'h0, tq.pop_front()});
      t_ref <= $time;
    end
    if (urow_wr_valid) check({19'h0, urow_wr_addr, urow_wr_data}, {19'h0, uq.pop_front()});
    if (sync_event) ev_cnt++;
  end
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end
  initial begin
    seed = 32'hC01C;
    {hresetn, ce, hsel, hwrite, chk, go, info, sync_window, sync_line} = '0;
    {ram_wr_valid, port_disable, port_reset, in_sleep} = '0;
    {htrans, size, ram_wr_data, ram_wr_addr, haddr, hwdata, key} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ce <= 1'b1;
    @(posedge hclk);
    in_sleep <= 1'b1;
    rd(stat_addr, 32'h11);
    in_sleep <= 1'b0;
    rd(sctl_addr, 32'h01);
    rd(8'h3C, 32'h0);
    send(1'b0, 5'h08, {$random(seed), $random(seed)});
    rd(keys_addr, 32'h0);
    send(1'b0, 5'h08, debug_port_pkg::KEY_UROW);
    rd(keys_addr, 32'h20);
    wr(rreq_addr, RSIG);
    rd(stat_addr, 32'h21);
    wr(rreq_addr, 32'h0);
    repeat (2) @(posedge hclk);
    rd(stat_addr, 32'h05);
    check({31'h0, ram_read_allowed}, 32'h0);
    for (int i = 0; i < 33; i++) begin
      d = 8'($random(seed));
      ram_wr_valid <= 1'b1;
      ram_wr_addr <= (i == 32) ? 16'h0040 : 16'(i);
      ram_wr_data <= d;
      if (i < 32) uq.push_back({5'(i), d});
      @(posedge hclk);
    end
    ram_wr_valid <= 1'b0;
    wr(sctl_addr, 32'h02);
    repeat (40) @(posedge hclk);
    check(32'(uq.size()), 32'h0);
    check({30'h0, hresp, clk_request}, 32'h0);
    rd(stat_addr, 32'h01);
    wr(keys_addr, 32'h20);
    rd(keys_addr, 32'h0);
    send(1'b0, 5'h08, debug_port_pkg::KEY_ERASE);
    rd(keys_addr, 32'h08);
    wr(rreq_addr, RSIG);
    wr(rreq_addr, 32'h0);
    repeat (2) @(negedge hclk);
    check({brownout_level, brownout_active}, {3'h5, debug_port_pkg::BROWNOUT_ACTIVE_ON});
    repeat (20) @(posedge hclk);
    rd(stat_addr, 32'h0);
    check({31'h0, sys_bus_grant}, 32'h1);
    send(1'b0, 5'h08, debug_port_pkg::KEY_PROG);
    send(1'b0, 5'h08, debug_port_pkg::KEY_ERASE);
    rd(keys_addr, 32'h18);
    port_disable <= 1'b1;
    @(posedge hclk);
    port_disable <= 1'b0;
    rd(keys_addr, 32'h10);
    port_reset <= 1'b1;
    @(posedge hclk);
    port_reset <= 1'b0;
    rd(keys_addr, 32'h0);
    send(1'b0, 5'h08, debug_port_pkg::KEY_PROG);
    wr(rreq_addr, RSIG);
    wr(rreq_addr, 32'h0);
    repeat (2) @(posedge hclk);
    rd(stat_addr, 32'h08);
    wr(rreq_addr, RSIG);
    wr(rreq_addr, 32'h0);
    rd(keys_addr, 32'h0);
    stream(1'b1, 8);
    stream(1'b0, 16);
    sync_window <= 1'b1;
    exp_ev = 0;
    for (int i = 0; i < 16; i++) begin
      d[0] = 1'($random(seed));
      if (d[0] && !sync_line) exp_ev++;
      sync_line <= d[0];
      @(posedge hclk);
    end
    sync_window <= 1'b0;
    sync_line <= 1'b0;
    repeat (3) @(posedge hclk);
    check(32'(ev_cnt), 32'(exp_ev));
    stop_test();
  end
endmodule
